// ---- flash_self_access_defs.svh ----
// offsets, field positions, reset values and timing counts for the flash self-access control block
// included by the control module and the test bench
`ifndef FLASH_SELF_ACCESS_DEFS_SVH
`define FLASH_SELF_ACCESS_DEFS_SVH
`define ADDR_W 2
`define OFS_ACCESS_CONTROL 2'h0
`define OFS_UNLOCK_KEY 2'h1
`define BIT_ENABLE 2
`define BIT_LAUNCH 1
`define BIT_FETCH 0
`define ACCESS_CONTROL_RESET 8'h00
`define UNLOCK_FIRST 8'h55
`define UNLOCK_SECOND 8'haa
`define FETCH_SLOT 2'h2
`endif

// ---- flash_self_access_pkg.sv ----
// types for the flash self-access control block
// offsets and counts live in flash_self_access_defs.svh
package flash_self_access_pkg;
  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_HALF = 3'b010,
    KEY_OPEN = 3'b100
  } key_state_t;
  typedef struct packed {
    logic enable;
    logic launch;
    logic fetch;
  } ctrl_bits_t;
endpackage : flash_self_access_pkg

// ---- flash_self_access_control.sv ----
// control register for cpu self-timed flash reads and program/erase operations
// assumes a single-cycle register port and a flash engine that pulses done when a program/erase ends
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "flash_self_access_defs.svh"

module flash_self_access_control
  import flash_self_access_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // register port
  input wire logic [`ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // flash engine
  input wire logic i_prog_done,
  output logic o_prog_start,
  output logic o_fetch_strobe,
  output logic o_slot_skip
);

  ctrl_bits_t ctrl;
  key_state_t key_state;
  logic [1:0] fetch_age;
  logic fetch_pending;

  function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire logic ctrl_wr = i_wr && hit(i_addr, `OFS_ACCESS_CONTROL);
  wire logic key_wr = i_wr && hit(i_addr, `OFS_UNLOCK_KEY);
  // a launch only counts with enable written as one in the same access
  wire logic next_enable = ctrl_wr ? i_wdata[`BIT_ENABLE] : ctrl.enable;
  wire logic launch_ok = ctrl_wr && i_wdata[`BIT_LAUNCH] && !ctrl.launch && next_enable &&
                         (key_state == KEY_OPEN);

  // unlock sequencer: any other write in between closes the key
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      key_state <= KEY_IDLE;
    end else if (i_wr) begin
      case (key_state)
        KEY_IDLE: key_state <= (key_wr && i_wdata == `UNLOCK_FIRST) ? KEY_HALF : KEY_IDLE;
        KEY_HALF: key_state <= (key_wr && i_wdata == `UNLOCK_SECOND) ? KEY_OPEN :
                               ((key_wr && i_wdata == `UNLOCK_FIRST) ? KEY_HALF : KEY_IDLE);
        KEY_OPEN: key_state <= (key_wr && i_wdata == `UNLOCK_FIRST) ? KEY_HALF : KEY_IDLE;
        default: key_state <= KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ctrl.enable <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl.enable <= i_wdata[`BIT_ENABLE];
    end
  end

  // launch bit is set-only from software; done clears it unless a new launch arrives that cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ctrl.launch <= 1'b0;
      o_prog_start <= 1'b0;
    end else begin
      o_prog_start <= launch_ok;
      if (launch_ok) begin
        ctrl.launch <= 1'b1;
      end else if (i_prog_done) begin
        ctrl.launch <= 1'b0;
      end
    end
  end

  // fetch: set-only bit, flash read in the second cycle after the set, then cleared
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ctrl.fetch <= 1'b0;
      fetch_age <= 2'h0;
      fetch_pending <= 1'b0;
      o_fetch_strobe <= 1'b0;
      o_slot_skip <= 1'b0;
    end else begin
      o_fetch_strobe <= 1'b0;
      o_slot_skip <= 1'b0;
      if (ctrl_wr && i_wdata[`BIT_FETCH] && !fetch_pending) begin
        ctrl.fetch <= 1'b1;
        fetch_pending <= 1'b1;
        fetch_age <= 2'h1;
      end else if (fetch_pending) begin
        if (fetch_age == `FETCH_SLOT) begin
          o_fetch_strobe <= 1'b1;
          o_slot_skip <= 1'b1;
          ctrl.fetch <= 1'b0;
          fetch_pending <= 1'b0;
          fetch_age <= 2'h0;
        end else begin
          fetch_age <= fetch_age + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_rdata <= `ACCESS_CONTROL_RESET;
    end else if (i_rd && hit(i_addr, `OFS_ACCESS_CONTROL)) begin
      o_rdata <= {5'h00, ctrl.enable, ctrl.launch, ctrl.fetch};
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // read port checks: every read answers in the next cycle only, unused bits and the key port read zero

  a_upper_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $past(i_rd) |-> o_rdata[7:3] == 5'h00) else $error("upper control bits not zero");

  a_key_reads_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_rd && hit(i_addr, `OFS_UNLOCK_KEY) |=> o_rdata == 8'h00) else $error("key port read nonzero");

  a_rdata_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside read slot");

  // program/erase launch checks

  a_start_needs_enable: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_prog_start |-> ctrl.enable) else $error("program start with enable clear");

  a_start_needs_key: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_prog_start |-> $past(key_state) == KEY_OPEN) else $error("program start without key");

  a_no_start_disabled: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ctrl_wr && !i_wdata[`BIT_ENABLE] |=> !o_prog_start) else $error("start while disabling");

  a_no_start_locked: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    key_state != KEY_OPEN |=> !o_prog_start) else $error("start with key closed");

  a_enable_follows: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ctrl_wr |=> ctrl.enable == $past(i_wdata[`BIT_ENABLE])) else $error("enable bit not written");

  a_key_onehot: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $onehot(key_state)) else $error("key sequencer state corrupt");

  a_start_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_prog_start |=> !o_prog_start) else $error("program start longer than one cycle");

  a_start_sets_launch: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_prog_start |-> ctrl.launch) else $error("launch bit low at start");

  a_launch_sticks: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ctrl.launch && !i_prog_done |=> ctrl.launch) else $error("launch bit cleared early");

  a_zero_keeps_launch: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ctrl_wr && !i_wdata[`BIT_LAUNCH] && ctrl.launch && !i_prog_done |=> ctrl.launch)
    else $error("written zero cleared launch");

  a_launch_clears: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ctrl.launch && i_prog_done && !launch_ok |=> !ctrl.launch) else $error("launch bit not cleared");

  // fetch checks: the bit is seen high for two cycles and the strobe lands in the cycle after

  a_fetch_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ctrl_wr && i_wdata[`BIT_FETCH] && !fetch_pending |=> ctrl.fetch) else $error("fetch bit not set");

  a_zero_keeps_fetch: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ctrl_wr && !i_wdata[`BIT_FETCH] && ctrl.fetch && fetch_age != `FETCH_SLOT |=> ctrl.fetch)
    else $error("written zero cleared fetch");

  a_fetch_slot: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $rose(ctrl.fetch) |-> !o_fetch_strobe ##2 o_fetch_strobe && o_slot_skip) else $error("fetch slot wrong");

  a_fetch_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $rose(ctrl.fetch) |-> ctrl.fetch [*2] ##1 !ctrl.fetch) else $error("fetch bit not cleared");

  a_skip_with_strobe: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_fetch_strobe == o_slot_skip) else $error("slot skip apart from strobe");

  a_strobe_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_fetch_strobe |=> !o_fetch_strobe) else $error("fetch strobe longer than one cycle");

  a_fetch_age_range: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    fetch_age <= `FETCH_SLOT) else $error("fetch age out of range");

  a_pending_matches: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    fetch_pending == ctrl.fetch) else $error("fetch pending apart from fetch bit");

  // a second fetch written while one is pending is dropped rather than queued,
  // so software must wait for the bit to read zero before asking again

endmodule : flash_self_access_control

// ---- flash_self_access_control_test.sv ----
// self-checking bench for the flash self-access control block, with a reference model
// assumes the control module, its package and its defs header compile ahead of this file
`timescale 1ns/1ps
`include "flash_self_access_defs.svh"
module flash_self_access_control_test;
  import flash_self_access_pkg::*;
  logic i_ref_clk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, i_prog_done = 0;
  logic [1:0] i_addr = 0;
  logic [7:0] i_wdata = 0;
  logic [7:0] o_rdata;
  logic o_prog_start, o_fetch_strobe, o_slot_skip, en = 0, launch = 0;
  logic [31:0] r;
  int errors = 0, checks_done = 0, nstart = 0, nfetch = 0, estart = 0, efetch = 0, key = 0;
  always #2 i_ref_clk = ~i_ref_clk;
  flash_self_access_control i_flash_self_access_control(.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_prog_done(i_prog_done), .o_prog_start(o_prog_start), .o_fetch_strobe(o_fetch_strobe),
    .o_slot_skip(o_slot_skip));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  always @(negedge i_ref_clk) begin
    if (o_prog_start === 1'b1) nstart++;
    if (o_fetch_strobe === 1'b1) nfetch++;
    chk("slot_skip", o_fetch_strobe, o_slot_skip);
  end
  // model settles after the write is taken; the idle gap lets a fetch finish first
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge i_ref_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_ref_clk) i_wr <= 0;
    if (a == `OFS_UNLOCK_KEY) key = (d == `UNLOCK_FIRST) ? 1 : (key == 1 && d == `UNLOCK_SECOND) ? 2 : 0;
    else begin
      if (a == `OFS_ACCESS_CONTROL) begin
        en = d[`BIT_ENABLE];
        if (d[`BIT_LAUNCH] && key == 2 && en && !launch) begin
          launch = 1;
          estart++;
        end
        if (d[`BIT_FETCH]) efetch++;
      end
      key = 0;
    end
    repeat (4) @(posedge i_ref_clk);
  endtask : wr
  task automatic rd(logic [1:0] a);
    @(posedge i_ref_clk) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_ref_clk) i_rd <= 0;
    #1 chk("rdata", (a == `OFS_ACCESS_CONTROL) ? {5'h00, en, launch, 1'b0} : 8'h00, o_rdata);
  endtask : rd
  task automatic done_pulse;
    @(posedge i_ref_clk) i_prog_done <= 1;
    @(posedge i_ref_clk) i_prog_done <= 0;
    launch = 0;
    repeat (2) @(posedge i_ref_clk);
  endtask : done_pulse
  task automatic counts(string name);
    chk("prog_start count", estart, nstart);
    chk("fetch count", efetch, nfetch);
    $display("test %s done", name);
  endtask : counts
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    void'($urandom(32'h2c0c3b50));
    repeat (10) @(posedge i_ref_clk);
    i_rstn <= 1;
    rd(0);
    rd(1);
    rd(2);
    counts("reset");
    wr(0, 8'hff);
    rd(0);
    wr(0, 8'h00);
    rd(0);
    counts("bits");
    wr(1, 8'h55);
    wr(1, 8'haa);
    wr(0, 8'h02);
    counts("disabled");
    wr(1, 8'h55);
    wr(3, 8'h00);
    wr(1, 8'haa);
    wr(0, 8'h06);
    counts("broken_key");
    wr(1, 8'h55);
    wr(1, 8'haa);
    wr(0, 8'h06);
    wr(0, 8'h00);
    rd(0);
    counts("launch");
    done_pulse();
    rd(0);
    counts("done");
    repeat (80) begin
      r = $urandom;
      case (r % 5)
        0: wr(1, 8'h55);
        1: wr(1, 8'haa);
        2: wr(r[9:8], r[23:16]);
        3: done_pulse();
        default: rd(r[9:8]);
      endcase
    end
    counts("random");
    print_verdict();
  end
endmodule : flash_self_access_control_test
